// *** sqs_pkg.sv ***
/*
  Package for the serial quad status block: register offsets, field
  layout, reset values, carriers, plus the sticky event flag module.
  Assumes a single 200 MHz clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

package sqs_pkg;
  localparam int          SQS_AW          = 12;
  localparam int          SQS_DW          = 32;
  localparam int          SQS_NSTICKY     = 4;
  // Register byte offsets
  localparam logic [11:0] SQS_OFS_STAT2   = 12'h000;
  localparam logic [11:0] SQS_OFS_IRQ_STS = 12'h004;
  localparam logic [11:0] SQS_OFS_IRQ_MSK = 12'h008;
  // Field positions in serial_quad_status_two
  localparam int          SQS_CMD_LSB     = 16;
  localparam int          SQS_SPACE_LSB   = 7;
  localparam int          SQS_LINE_LSB    = 3;
  localparam int          SQS_RECEIVE_FIFO_UNDERFLOW_BIT    = 1;
  localparam int          SQS_TRANSMIT_FIFO_OVERFLOW_BIT    = 0;
  // Sticky flag indexes
  localparam int          SQS_STK_TRANSMIT_FIFO_OVERFLOW    = 0;
  localparam int          SQS_STK_RECEIVE_FIFO_UNDERFLOW    = 1;
  localparam int          SQS_STK_ITXOV   = 2;
  localparam int          SQS_STK_IRXUN   = 3;
  // Free space encoding
  localparam logic [5:0]  SQS_FREE_MAX    = 6'h20;
  localparam logic [5:0]  SQS_FREE_TOP    = 6'h1F;
  localparam logic [4:0]  SQS_SPACE_FULL  = 5'h1F;
  localparam logic [4:0]  SQS_SPACE_TOP   = 5'h1E;
  localparam logic [31:0] SQS_ZERO32      = 32'h0000_0000;
  localparam logic [1:0]  SQS_MASK_RST    = 2'h0;

  typedef enum logic [1:0] {
    SQS_CMD_IDLE = 2'b00,
    SQS_CMD_TX   = 2'b01,
    SQS_CMD_RX   = 2'b10,
    SQS_CMD_RSVD = 2'b11
  } sqs_cmd_t;

  // Status inputs from the transfer engine
  typedef struct packed {
    sqs_cmd_t   cmd;
    logic [5:0] fifo_free;
    logic [3:0] line_active;
    logic       rx_underflow;
    logic       tx_overflow;
  } sqs_core_in_t;

  // APB request
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [SQS_AW-1:0] paddr;
    logic [SQS_DW-1:0] pwdata;
  } sqs_apb_req_t;
endpackage

module sqs_sticky
  import sqs_pkg::*;
(
  input  wire logic                   ref_clk,  // Clock
  input  wire logic                   reset_n,  // Sync reset
  input  wire logic [SQS_NSTICKY-1:0] set_i,    // Event pulses
  input  wire logic [SQS_NSTICKY-1:0] clr_i,    // Clear pulses
  output logic      [SQS_NSTICKY-1:0] flag_q    // Sticky flags
);
  typedef struct packed {
    logic [SQS_NSTICKY-1:0] flag;
  } sqs_stk_state_t;

  sqs_stk_state_t st_q;
  sqs_stk_state_t st_d;

  always_comb begin
    st_d = st_q;
    for (int i = 0; i < SQS_NSTICKY; i++) begin
      // Set wins over clear
      st_d.flag[i] = set_i[i] | (st_q.flag[i] & ~clr_i[i]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign flag_q = st_q.flag;
endmodule

`default_nettype wire

// *** sqs_status_two.sv ***
/*
  Second status register of the serial quad controller, with APB slave,
  sticky event flags and one masked interrupt output.
  Assumes transfer-engine inputs synchronous to ref_clk, events one-cycle.
*/
// Behaviour
// - Bits 17:16 show the command state: 00 idle, 01 transmit, 10 receive, 11 never shown.
// - Bits 11:7 show free control FIFO space, all ones for 32 bytes down to zero for none.
// - Bit 6 is high while data line 3 carries data, one ref_clk cycle late.
// - Bit 5 is high while data line 2 carries data, one ref_clk cycle late.
// - Bits 31:18 and 15:12 always read zero.
// - Bit 4 follows data line 1 and bit 3 follows data line 0.
// - Bit 1 flags a receive FIFO underflow; bit 2 reads zero.
// - Bit 0 flags a transmit FIFO overflow.
`timescale 1ns/1ps
`default_nettype none

module sqs_status_two
  import sqs_pkg::*;
(
  input  wire logic              ref_clk,  // 200 MHz clock
  input  wire logic              reset_n,  // Sync reset, active low
  input  wire sqs_apb_req_t      apb_req,  // APB request
  output logic                   pready,   // APB ready
  output logic      [SQS_DW-1:0] prdata,   // APB read data
  output logic                   pslverr,  // APB error
  input  wire sqs_core_in_t      core_in,  // Engine status
  output logic                   irq       // Level interrupt
);
  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [1:0]        cmd;
    logic [4:0]        space;
    logic [3:0]        lines;
    logic [SQS_DW-1:0] rdata;
    logic              slverr;
    logic [1:0]        mask;
    logic              irq;
  } sqs_state_t;

  sqs_state_t             st_q;
  sqs_state_t             st_d;
  logic [SQS_NSTICKY-1:0] stk_q;
  logic [SQS_NSTICKY-1:0] stk_set;
  logic [SQS_NSTICKY-1:0] stk_clr;
  logic                   setup_rd;
  logic                   access;
  logic [SQS_DW-1:0]      stat2_val;
  logic [SQS_DW-1:0]      irq_val;
  logic [SQS_DW-1:0]      mask_val;

  //////////////////////////////////////////////////////////////////////////////
  // Register images
  always_comb begin
    stat2_val = SQS_ZERO32;
    stat2_val[SQS_CMD_LSB +: 2]   = st_q.cmd;
    stat2_val[SQS_SPACE_LSB +: 5] = st_q.space;
    stat2_val[SQS_LINE_LSB +: 4]  = st_q.lines;
    stat2_val[SQS_RECEIVE_FIFO_UNDERFLOW_BIT]       = stk_q[SQS_STK_RECEIVE_FIFO_UNDERFLOW];
    stat2_val[SQS_TRANSMIT_FIFO_OVERFLOW_BIT]       = stk_q[SQS_STK_TRANSMIT_FIFO_OVERFLOW];
    irq_val = SQS_ZERO32;
    irq_val[SQS_RECEIVE_FIFO_UNDERFLOW_BIT] = stk_q[SQS_STK_IRXUN];
    irq_val[SQS_TRANSMIT_FIFO_OVERFLOW_BIT] = stk_q[SQS_STK_ITXOV];
    mask_val = SQS_ZERO32;
    mask_val[1:0] = st_q.mask;
  end

  assign setup_rd = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
  assign access   = apb_req.psel & apb_req.penable;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    // Status fields track the engine every cycle
    st_d.cmd = (core_in.cmd == SQS_CMD_RSVD) ? SQS_CMD_IDLE : core_in.cmd;
    if (core_in.fifo_free >= SQS_FREE_MAX) begin
      st_d.space = SQS_SPACE_FULL;
    end else if (core_in.fifo_free == SQS_FREE_TOP) begin
      st_d.space = SQS_SPACE_TOP;
    end else begin
      st_d.space = core_in.fifo_free[4:0];
    end
    st_d.lines = core_in.line_active;
    // Read data latched in the setup cycle
    if (setup_rd) begin
      st_d.slverr = 1'b0;
      case (apb_req.paddr)
        SQS_OFS_STAT2:   st_d.rdata = stat2_val;
        SQS_OFS_IRQ_STS: st_d.rdata = irq_val;
        SQS_OFS_IRQ_MSK: st_d.rdata = mask_val;
        default: begin
          st_d.rdata  = SQS_ZERO32;
          st_d.slverr = 1'b1;
        end
      endcase
    end else if (apb_req.psel & ~apb_req.penable) begin
      st_d.rdata  = SQS_ZERO32;
      st_d.slverr = !(apb_req.paddr == SQS_OFS_STAT2 || apb_req.paddr == SQS_OFS_IRQ_STS ||
                      apb_req.paddr == SQS_OFS_IRQ_MSK);
    end
    // Only the mask is writable; status writes are ignored
    if (access && apb_req.pwrite && apb_req.paddr == SQS_OFS_IRQ_MSK) begin
      st_d.mask = apb_req.pwdata[1:0];
    end
    st_d.irq = |(irq_val[1:0] & st_d.mask);
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st_q <= '{cmd: SQS_CMD_IDLE, space: '0, lines: '0, rdata: SQS_ZERO32,
                slverr: 1'b0, mask: SQS_MASK_RST, irq: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sticky flags; a read clears only the bits it returned
  always_comb begin
    stk_set = '0;
    stk_clr = '0;
    stk_set[SQS_STK_RECEIVE_FIFO_UNDERFLOW]  = core_in.rx_underflow;
    stk_set[SQS_STK_TRANSMIT_FIFO_OVERFLOW]  = core_in.tx_overflow;
    stk_set[SQS_STK_IRXUN] = core_in.rx_underflow;
    stk_set[SQS_STK_ITXOV] = core_in.tx_overflow;
    if (access && !apb_req.pwrite && apb_req.paddr == SQS_OFS_STAT2) begin
      stk_clr[SQS_STK_RECEIVE_FIFO_UNDERFLOW] = st_q.rdata[SQS_RECEIVE_FIFO_UNDERFLOW_BIT];
      stk_clr[SQS_STK_TRANSMIT_FIFO_OVERFLOW] = st_q.rdata[SQS_TRANSMIT_FIFO_OVERFLOW_BIT];
    end
    if (access && !apb_req.pwrite && apb_req.paddr == SQS_OFS_IRQ_STS) begin
      stk_clr[SQS_STK_IRXUN] = st_q.rdata[SQS_RECEIVE_FIFO_UNDERFLOW_BIT];
      stk_clr[SQS_STK_ITXOV] = st_q.rdata[SQS_TRANSMIT_FIFO_OVERFLOW_BIT];
    end
  end

  sqs_sticky u_sticky (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .set_i   (stk_set),
    .clr_i   (stk_clr),
    .flag_q  (stk_q)
  );

  assign pready  = 1'b1;
  assign prdata  = st_q.rdata;
  assign pslverr = st_q.slverr & access;
  assign irq     = st_q.irq;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  AST_CMD_NO_RSVD: assert property (stat2_val[SQS_CMD_LSB +: 2] != SQS_CMD_RSVD)
    else $error("Reserved command state shown");
  AST_CMD_FOLLOW: assert property (core_in.cmd == SQS_CMD_TX |=> st_q.cmd == SQS_CMD_TX)
    else $error("Command state not followed");
  AST_SPACE_FULL: assert property (core_in.fifo_free == SQS_FREE_MAX |=> st_q.space == SQS_SPACE_FULL)
    else $error("Full space code wrong");
  AST_SPACE_ZERO: assert property (core_in.fifo_free == '0 |=> st_q.space == '0)
    else $error("Zero space code wrong");
  AST_LINE3: assert property ($past(reset_n) |-> st_q.lines[3] == $past(core_in.line_active[3]))
    else $error("Line 3 bit wrong");
  AST_LINE2: assert property (core_in.line_active[2] |=> stat2_val[5])
    else $error("Line 2 bit wrong");
  AST_RSVD_ZERO: assert property (stat2_val[31:18] == '0 && stat2_val[15:12] == '0 && !stat2_val[2])
    else $error("Reserved bits not zero");
  AST_LINE10: assert property ($past(reset_n) |-> stat2_val[4:3] == $past(core_in.line_active[1:0]))
    else $error("Line 1/0 bits wrong");
  AST_RECEIVE_FIFO_UNDERFLOW_SET: assert property (core_in.rx_underflow |=> stat2_val[SQS_RECEIVE_FIFO_UNDERFLOW_BIT])
    else $error("Underflow not flagged");
  AST_TRANSMIT_FIFO_OVERFLOW_SET: assert property (core_in.tx_overflow |=> stat2_val[SQS_TRANSMIT_FIFO_OVERFLOW_BIT] ##0 irq_val[0])
    else $error("Overflow not flagged");
  AST_WRITE_NOEFFECT: assert property (access && apb_req.pwrite && apb_req.paddr == SQS_OFS_STAT2
    && !core_in.rx_underflow && !core_in.tx_overflow |=> stk_q[1:0] == $past(stk_q[1:0]))
    else $error("Write changed status");
  AST_IRQ: assert property (st_q.irq == |(irq_val[1:0] & st_q.mask) || $changed(stk_q) || $changed(st_q.mask))
    else $error("Interrupt level mismatch");

  // Field decoding corners
  AST_SPACE_TOP: assert property (core_in.fifo_free == SQS_FREE_TOP |=> st_q.space == SQS_SPACE_TOP)
    else $error("Top space code wrong");
  AST_SPACE_COUNT: assert property (core_in.fifo_free < SQS_FREE_TOP
    |=> st_q.space == $past(core_in.fifo_free[4:0]))
    else $error("Space count wrong");
  AST_CMD_RX: assert property (core_in.cmd == SQS_CMD_RX |=> st_q.cmd == SQS_CMD_RX)
    else $error("Receive state not followed");
  AST_CMD_IDLE: assert property (core_in.cmd == SQS_CMD_IDLE || core_in.cmd == SQS_CMD_RSVD
    |=> st_q.cmd == SQS_CMD_IDLE)
    else $error("Idle state not shown");
  AST_LINE3_OFF: assert property (!core_in.line_active[3] |=> !stat2_val[SQS_LINE_LSB + 3])
    else $error("Line 3 bit stuck");
  AST_LINE2_OFF: assert property (!core_in.line_active[2] |=> !stat2_val[SQS_LINE_LSB + 2])
    else $error("Line 2 bit stuck");

  // Read-clear of the event bits
  AST_RECEIVE_FIFO_UNDERFLOW_CLEAR: assert property (access && !apb_req.pwrite && apb_req.paddr == SQS_OFS_STAT2
    && !core_in.rx_underflow && !$past(core_in.rx_underflow) |=> !stat2_val[SQS_RECEIVE_FIFO_UNDERFLOW_BIT])
    else $error("Underflow not cleared by read");
  AST_TRANSMIT_FIFO_OVERFLOW_CLEAR: assert property (access && !apb_req.pwrite && apb_req.paddr == SQS_OFS_STAT2
    && !core_in.tx_overflow && !$past(core_in.tx_overflow) |=> !stat2_val[SQS_TRANSMIT_FIFO_OVERFLOW_BIT])
    else $error("Overflow not cleared by read");

  // Bus side and interrupt
  AST_MASK_HOLD: assert property (!(access && apb_req.pwrite && apb_req.paddr == SQS_OFS_IRQ_MSK)
    |=> $stable(st_q.mask))
    else $error("Mask changed without its write");
  AST_MASK_WRITE: assert property (access && apb_req.pwrite && apb_req.paddr == SQS_OFS_IRQ_MSK
    |=> st_q.mask == $past(apb_req.pwdata[1:0]))
    else $error("Mask write lost");
  AST_SLVERR: assert property (pslverr == (access && apb_req.paddr != SQS_OFS_STAT2
    && apb_req.paddr != SQS_OFS_IRQ_STS && apb_req.paddr != SQS_OFS_IRQ_MSK))
    else $error("Error response wrong");
  AST_UNMAPPED_ZERO: assert property (pslverr |-> prdata == SQS_ZERO32)
    else $error("Unmapped read data not zero");
  AST_IRQ_MASKED: assert property (st_q.mask == SQS_MASK_RST |-> !irq)
    else $error("Masked interrupt raised");

  COV_RD_STAT2: cover property (setup_rd && apb_req.paddr == SQS_OFS_STAT2 ##1 access);
  COV_IRQ:      cover property (core_in.tx_overflow ##1 st_q.mask[0] ##1 irq);
  COV_RX:       cover property (st_q.cmd == SQS_CMD_RX ##1 st_q.cmd == SQS_CMD_IDLE);
  COV_UNMAPPED: cover property (access && pslverr);
  COV_SPACE:    cover property (st_q.space == SQS_SPACE_FULL ##1 st_q.space == SQS_SPACE_TOP);
endmodule

`default_nettype wire

// *** sqs_flash_model.sv ***
/*
  Far-side model: reports quad flash line activity and engine status.
  Assumes the bench sets each level after a rising edge of ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module sqs_flash_model
  import sqs_pkg::*;
(
  input  wire logic [1:0] cmd,      // Command state
  input  wire logic [5:0] free,     // Control FIFO free bytes
  input  wire logic [3:0] lines,    // Data present on lines 3..0
  input  wire logic       rx_ev,    // Underflow pulse
  input  wire logic       tx_ev,    // Overflow pulse
  output sqs_core_in_t    core_in   // Status toward the block
);
  // Each data line reports activity only while the flash drives it
  assign core_in = '{cmd: sqs_cmd_t'(cmd), fifo_free: free, line_active: lines,
                     rx_underflow: rx_ev, tx_overflow: tx_ev};
endmodule

`default_nettype wire

// *** test_serial_quad_status_two.sv ***
/*
  Self-checking bench for the second status register over APB.
  Assumes an APB slave that answers with pready and one-cycle status sampling.
*/
`timescale 1ns/1ps
`default_nettype none

module test_serial_quad_status_two
  import sqs_pkg::*;
;
  logic         ref_clk = 1'b0;
  logic         reset_n = 1'b0;
  sqs_apb_req_t req     = '0;
  logic         pready;
  logic [31:0]  prdata;
  logic         pslverr;
  logic         irq;
  sqs_core_in_t core_in;
  logic [1:0]   cmd     = 2'h0;
  logic [5:0]   free    = 6'h00;
  logic [3:0]   lines   = 4'h0;
  logic         rx_ev   = 1'b0;
  logic         tx_ev   = 1'b0;
  int           n_errors  = 0;
  int           num_checks = 0;
  logic [31:0]  rd;
  logic         er;

  always #2.5 ref_clk = ~ref_clk;

  sqs_flash_model fm_u (.cmd(cmd), .free(free), .lines(lines), .rx_ev(rx_ev), .tx_ev(tx_ev), .core_in(core_in));
  sqs_status_two dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .apb_req(req), .pready(pready),
                        .prdata(prdata), .pslverr(pslverr), .core_in(core_in), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  function automatic logic [31:0] exp_stat(logic [1:0] c, logic [5:0] f, logic [3:0] l);
    logic [4:0] sp;
    sp = (f >= 6'd32) ? 5'h1F : (f == 6'd31) ? 5'h1E : f[4:0];
    return {14'h0, (c == 2'h3) ? 2'h0 : c, 4'h0, sp, l, 3'h0};
  endfunction

  task automatic pulse(input logic r, input logic t);
    @(posedge ref_clk);
    rx_ev <= r;
    tx_ev <= t;
    @(posedge ref_clk);
    rx_ev <= 1'b0;
    tx_ev <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic test_done();
    $display("Checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    test_done();
  end

  initial begin
    void'($urandom(32'h0489_4687));
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    apb(1'b0, SQS_OFS_STAT2, 32'h0);
    chk("stat2 reset", rd, 32'h0000_0000);
    chk("irq reset", {31'h0, irq}, 32'h0000_0000);
    $display("Reset test done");
    for (int i = 0; i < 40; i++) begin
      @(posedge ref_clk);
      cmd   <= (i < 4) ? i[1:0] : 2'($urandom_range(3));
      free  <= (i < 4) ? 6'(32 - i) : (i == 4) ? 6'h00 : 6'($urandom_range(32));
      lines <= 4'($urandom);
      apb(1'b0, SQS_OFS_STAT2, 32'h0);
      chk("stat2 fields", rd, exp_stat(cmd, free, lines));
    end
    $display("Field test done");
    apb(1'b1, SQS_OFS_STAT2, 32'hFFFF_FFFF);
    apb(1'b0, SQS_OFS_STAT2, 32'h0);
    chk("stat2 after write", rd, exp_stat(cmd, free, lines));
    chk("stat2 no error", {31'h0, er}, 32'h0000_0000);
    pulse(1'b0, 1'b1);
    apb(1'b0, SQS_OFS_STAT2, 32'h0);
    chk("overflow set", rd, exp_stat(cmd, free, lines) | 32'h0000_0001);
    pulse(1'b1, 1'b0);
    apb(1'b0, SQS_OFS_STAT2, 32'h0);
    chk("underflow set", rd, exp_stat(cmd, free, lines) | 32'h0000_0002);
    apb(1'b0, SQS_OFS_STAT2, 32'h0);
    chk("events cleared", rd, exp_stat(cmd, free, lines));
    $display("Event test done");
    apb(1'b0, SQS_OFS_IRQ_STS, 32'h0);
    chk("irq status both", rd, 32'h0000_0003);
    apb(1'b1, SQS_OFS_IRQ_MSK, 32'h0000_0003);
    apb(1'b0, SQS_OFS_IRQ_MSK, 32'h0);
    chk("mask readback", rd, 32'h0000_0003);
    pulse(1'b0, 1'b1);
    chk("irq raised", {31'h0, irq}, 32'h0000_0001);
    apb(1'b0, SQS_OFS_IRQ_STS, 32'h0);
    chk("irq status", rd, 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
    chk("irq cleared", {31'h0, irq}, 32'h0000_0000);
    apb(1'b1, SQS_OFS_IRQ_MSK, 32'h0000_0000);
    pulse(1'b1, 1'b0);
    chk("irq masked", {31'h0, irq}, 32'h0000_0000);
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped error", {31'h0, er}, 32'h0000_0001);
    chk("unmapped data", rd, 32'h0000_0000);
    $display("Interrupt test done");
    apb(1'b1, SQS_OFS_IRQ_MSK, 32'h0000_0003);
    pulse(1'b1, 1'b1);
    chk("irq before reset", {31'h0, irq}, 32'h0000_0001);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    chk("irq after reset", {31'h0, irq}, 32'h0000_0000);
    chk("pready idle", {31'h0, pready}, 32'h0000_0001);
    apb(1'b0, SQS_OFS_STAT2, 32'h0);
    chk("stat2 after reset", rd, exp_stat(cmd, free, lines));
    apb(1'b0, SQS_OFS_IRQ_MSK, 32'h0);
    chk("mask after reset", rd, 32'h0000_0000);
    $display("Reset rerun test done");
    test_done();
  end
endmodule

`default_nettype wire
